// File: src/rbd_pkg.sv
// Package of the ring buffer DMA engine: register map, fields, types and shared functions.
package rbd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int AV_AW = 8; // Byte address width of the register window
  localparam int AV_DW = 32; // Register data width

  // Register byte offsets, one aligned word each
  localparam logic [7:0] REG_CTRL = 8'h00; // Run, direction, channel mask, dual module
  localparam logic [7:0] REG_BUF_LEN = 8'h04; // Host buffer length in bytes
  localparam logic [7:0] REG_NOTIFY = 8'h08; // Notify size in bytes
  localparam logic [7:0] REG_RELEASE = 8'h0c; // Bytes handed back to the card (write only)
  localparam logic [7:0] REG_HOST_READY = 8'h10; // host_ready_bytes (read only)
  localparam logic [7:0] REG_HOST_POS = 8'h14; // Host read position (read only)
  localparam logic [7:0] REG_CARD_FREE = 8'h18; // card_free_bytes (read only)
  localparam logic [7:0] REG_STATUS = 8'h1c; // Engine state (read only)
  localparam logic [2:0] PAGE_SEL = 3'h1; // address[7:5] value of the page table window

  // Field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_DIR = 1; // 0 card to host, 1 host to card
  localparam int CTRL_MASK_LSB = 4;
  localparam int CTRL_DUAL = 8;
  localparam int STAT_RUN = 0;
  localparam int STAT_OVR = 1;
  localparam int STAT_UNR = 2;
  localparam int STAT_ACT = 3;
  localparam int STAT_PRIMED = 4;

  // Scatter-gather page geometry, 4 kByte pages
  localparam int PAGE_SHIFT = 12;
  localparam int PAGE_IDX_W = 3;
  localparam int NUM_PAGES = 8;

  // Sample geometry
  localparam int NUM_CH = 4;
  localparam int NUM_MOD = 2;
  localparam int SMP_W = 8;

  // Reset values
  localparam logic [31:0] RST_BUF_LEN = 32'h0000_8000;
  localparam logic [31:0] RST_NOTIFY = 32'h0000_1000;
  localparam logic [3:0] RST_MASK = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // One sampling round: [module][channel] two's complement bytes
  typedef struct packed {
    logic [NUM_MOD-1:0][NUM_CH-1:0][SMP_W-1:0] smp;
  } rbd_round_t;

  // Busmaster command toward host memory, one byte per access
  typedef struct packed {
    logic req;
    logic wr;
    logic [31:0] addr;
    logic [7:0] wdata;
  } rbd_dma_req_t;

  // DMA sequencer states
  typedef enum logic [3:0] {
    DS_IDLE = 4'b0001,
    DS_FETCH = 4'b0010,
    DS_WRITE = 4'b0100,
    DS_READ = 4'b1000
  } rbd_dma_st_t;

  // Bytes produced by one sampling round
  function automatic logic [3:0] rbd_round_bytes(input logic [3:0] mask, input logic dual);
    logic [3:0] n;
    n = 4'h0;
    for (int c = 0; c < NUM_CH; c++)
      n = n + {3'h0, mask[c]};
    return dual ? {n[2:0], 1'b0} : n;
  endfunction

endpackage

// File: src/rbd_fifo_mem.sv
// On-board sample memory used as the FIFO store, with registered read data.
`timescale 1ns/1ns
module rbd_fifo_mem #(
  parameter int W = 8,
  parameter int AW = 10
) (
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data_r
);

  logic [W-1:0] mem [0:(1<<AW)-1]; // Storage, no reset so it maps onto block RAM

  ////////////////////////////////////////////////////////////////////////////
  // Write port and registered read port; data appear one edge after rd_en
  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en)
    begin
      rd_data_r <= mem[rd_addr];
    end
  end

endmodule // rbd_fifo_mem

// File: src/rbd_interleave.sv
// Turns one sampling round into the multiplexed byte order of the host buffer.
`timescale 1ns/1ns
module rbd_interleave (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic round_valid,
  input rbd_pkg::rbd_round_t round_in,
  input wire logic [3:0] ch_mask,
  input wire logic dual,
  input wire logic byte_ready,
  output logic busy,
  output logic [7:0] byte_data
);

  rbd_pkg::rbd_round_t cap_r, cap_nxt; // Captured round
  logic [2:0] idx_r, idx_nxt; // Index of the byte on byte_data
  logic busy_r, busy_nxt; // Bytes still to hand out
  logic [7:0] byte_r, byte_nxt; // Current byte, registered
  logic [3:0] cnt;

  // Channel for a slot; four channels go 0,2,1,3, otherwise ascending
  function automatic logic [1:0] slot_chan(input logic [2:0] slot, input logic [3:0] mask);
    logic [2:0] seen;
    logic [1:0] ch;
    seen = 3'h0;
    ch = 2'h0;
    if (mask == 4'hf)
      ch = {slot[0], slot[1]};
    else
      for (int c = 0; c < rbd_pkg::NUM_CH; c++)
        if (mask[c])
        begin
          if (seen == slot)
            ch = c[1:0];
          seen = seen + 3'h1;
        end
    return ch;
  endfunction

  // Byte i of a round; with two modules the modules alternate per byte, module 0 first in each slot
  function automatic logic [7:0] pick(input rbd_pkg::rbd_round_t r, input logic [2:0] i,
                                      input logic [3:0] mask, input logic dl);
    logic [2:0] slot;
    logic md;
    slot = dl ? {1'b0, i[2:1]} : i;
    md = dl & i[0];
    // Converter MSB lands on bit 7, code kept as two's complement
    return r.smp[md][slot_chan(slot, mask)];
  endfunction

  assign cnt = rbd_pkg::rbd_round_bytes(ch_mask, dual);
  assign busy = busy_r;
  assign byte_data = byte_r;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: capture when idle, step one byte per accepted cycle
  always_comb
  begin
    cap_nxt = cap_r;
    idx_nxt = idx_r;
    busy_nxt = busy_r;
    byte_nxt = byte_r;
    if (!busy_r && round_valid)
    begin
      cap_nxt = round_in;
      idx_nxt = 3'h0;
      busy_nxt = 1'b1;
      byte_nxt = pick(round_in, 3'h0, ch_mask, dual);
    end
    else if (busy_r && byte_ready)
    begin
      if ({1'b0, idx_r} + 4'h1 == cnt)
      begin
        busy_nxt = 1'b0; // Last byte of the round taken
      end
      else
      begin
        idx_nxt = idx_r + 3'h1;
        byte_nxt = pick(cap_r, idx_r + 3'h1, ch_mask, dual);
      end
    end
  end

  // Registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_r <= '0;
      idx_r <= 3'h0;
      busy_r <= 1'b0;
      byte_r <= 8'h00;
    end
    else
    begin
      cap_r <= cap_nxt;
      idx_r <= idx_nxt;
      busy_r <= busy_nxt;
      byte_r <= byte_nxt;
    end
  end

endmodule // rbd_interleave

// File: src/rbd_ring_dma.sv
// Ring buffer busmaster DMA engine between on-board FIFO memory and a host buffer.
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ns
module rbd_ring_dma #(
  parameter int FIFO_AW = 10
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [rbd_pkg::AV_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [rbd_pkg::AV_DW-1:0] avs_writedata,
  output logic [rbd_pkg::AV_DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic adc_round_valid,
  input rbd_pkg::rbd_round_t adc_round,
  input wire logic dac_ready,
  output logic dac_valid,
  output logic [7:0] dac_data,
  output rbd_pkg::rbd_dma_req_t dma_cmd,
  input wire logic dma_ack,
  input wire logic [7:0] dma_rdata,
  output logic data_avail_evt
);

  localparam logic [FIFO_AW:0] DEPTH = (FIFO_AW+1)'(1 << FIFO_AW); // FIFO capacity in bytes

  // Bus slave and configuration
  logic ack_r, ack_nxt; // Second cycle of an access
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [31:0] len_r, len_nxt;
  logic [31:0] notify_r, notify_nxt;
  logic [31:0] page_r [rbd_pkg::NUM_PAGES];
  logic [31:0] page_nxt [rbd_pkg::NUM_PAGES];
  logic wr_acc; // Write takes effect this edge
  logic start, rel;

  // Engine state
  rbd_pkg::rbd_dma_st_t st_r, st_nxt;
  logic run_r, run_nxt;
  logic ovr_r, ovr_nxt;
  logic unr_r, unr_nxt;
  logic primed_r, primed_nxt; // Output FIFO filled once or whole buffer fetched
  logic [31:0] ready_r, ready_nxt; // host_ready_bytes
  logic [31:0] free_r, free_nxt; // card_free_bytes
  logic [31:0] pos_r, pos_nxt; // Host read position
  logic [31:0] off_r, off_nxt; // DMA offset in host buffer
  logic [31:0] blk_r, blk_nxt; // Bytes in the block being built
  logic [31:0] addr_r, addr_nxt;
  logic [7:0] wdat_r, wdat_nxt;
  logic evt_r, evt_nxt;
  logic [FIFO_AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [FIFO_AW:0] cnt_r, cnt_nxt;
  logic dvld_r, dvld_nxt, dpend_r, dpend_nxt;
  logic [7:0] ddat_r, ddat_nxt;

  // Datapath wires
  logic gen; // Host to card direction
  logic push, pop, mem_pop;
  logic [7:0] push_data, mem_q;
  logic ilv_busy, ilv_ready, round_ok, ovr_hit;
  logic [7:0] ilv_byte;
  logic [3:0] round_bytes;
  logic byte_done, blk_full;
  logic [31:0] pos_sum;

  assign gen = ctrl_r[rbd_pkg::CTRL_DIR];
  assign wr_acc = avs_write && ack_r;
  assign start = wr_acc && avs_address == rbd_pkg::REG_CTRL && avs_writedata[rbd_pkg::CTRL_RUN] && !run_r;
  assign rel = wr_acc && avs_address == rbd_pkg::REG_RELEASE && run_r;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign avs_readdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, read data loaded on the first cycle of the access
  always_comb
  begin
    ack_nxt = (avs_read || avs_write) && !ack_r;
    rdata_nxt = rdata_r;
    ctrl_nxt = ctrl_r;
    len_nxt = len_r;
    notify_nxt = notify_r;
    for (int p = 0; p < rbd_pkg::NUM_PAGES; p++)
      page_nxt[p] = page_r[p];
    if (avs_read && !ack_r)
    begin
      unique case (avs_address)
        rbd_pkg::REG_CTRL: rdata_nxt = ctrl_r;
        rbd_pkg::REG_BUF_LEN: rdata_nxt = len_r;
        rbd_pkg::REG_NOTIFY: rdata_nxt = notify_r;
        rbd_pkg::REG_HOST_READY: rdata_nxt = ready_r;
        rbd_pkg::REG_HOST_POS: rdata_nxt = pos_r;
        rbd_pkg::REG_CARD_FREE: rdata_nxt = free_r;
        rbd_pkg::REG_STATUS: rdata_nxt = {27'h0, primed_r, st_r != rbd_pkg::DS_IDLE, unr_r, ovr_r, run_r};
        default:
          // Page table window, anything else reads zero
          rdata_nxt = (avs_address[7:5] == rbd_pkg::PAGE_SEL) ? page_r[avs_address[4:2]] : 32'h0;
      endcase
    end
    if (wr_acc)
    begin
      unique case (avs_address)
        rbd_pkg::REG_CTRL: ctrl_nxt = {23'h0, avs_writedata[8:4], 2'h0, avs_writedata[1:0]};
        // Geometry is frozen while running so the counters stay coherent
        rbd_pkg::REG_BUF_LEN: len_nxt = run_r ? len_r : avs_writedata;
        rbd_pkg::REG_NOTIFY: notify_nxt = run_r ? notify_r : avs_writedata;
        default:
          if (avs_address[7:5] == rbd_pkg::PAGE_SEL && !run_r)
            page_nxt[avs_address[4:2]] = {avs_writedata[31:rbd_pkg::PAGE_SHIFT], 12'h000};
      endcase
    end
  end

  // Registers of the bus slave
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
      ctrl_r <= {23'h0, rbd_pkg::RST_MASK, 4'h0};
      len_r <= rbd_pkg::RST_BUF_LEN;
      notify_r <= rbd_pkg::RST_NOTIFY;
      for (int p = 0; p < rbd_pkg::NUM_PAGES; p++)
        page_r[p] <= 32'h0;
    end
    else
    begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r <= ctrl_nxt;
      len_r <= len_nxt;
      notify_r <= notify_nxt;
      for (int p = 0; p < rbd_pkg::NUM_PAGES; p++)
        page_r[p] <= page_nxt[p];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acquisition front end: a whole round is refused if the FIFO cannot take it
  assign round_bytes = rbd_pkg::rbd_round_bytes(ctrl_r[7:4], ctrl_r[rbd_pkg::CTRL_DUAL]);
  assign ovr_hit = adc_round_valid && run_r && !gen && !ovr_r &&
                   (ilv_busy || cnt_r + {{(FIFO_AW-3){1'b0}}, round_bytes} > DEPTH);
  assign round_ok = adc_round_valid && run_r && !gen && !ovr_r && !ovr_hit;
  assign ilv_ready = cnt_r < DEPTH;

  rbd_interleave u_ilv (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .round_valid(round_ok),
    .round_in(adc_round),
    .ch_mask(ctrl_r[7:4]),
    .dual(ctrl_r[rbd_pkg::CTRL_DUAL]),
    .byte_ready(ilv_ready),
    .busy(ilv_busy),
    .byte_data(ilv_byte)
  );

  // FIFO write from interleaver or from host reads; read by DMA or output
  assign push = gen ? (st_r == rbd_pkg::DS_READ && dma_ack) : (ilv_busy && ilv_ready);
  assign push_data = gen ? dma_rdata : ilv_byte;
  assign mem_pop = gen ? (run_r && primed_r && !dvld_r && !dpend_r && cnt_r != '0 && !unr_r) : pop;

  rbd_fifo_mem #(.W(8), .AW(FIFO_AW)) u_mem (
    .core_clk(core_clk),
    .wr_en(push),
    .wr_addr(wp_r),
    .wr_data(push_data),
    .rd_en(mem_pop),
    .rd_addr(rp_r),
    .rd_data_r(mem_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // DMA sequencer and ring counters
  assign byte_done = (st_r == rbd_pkg::DS_WRITE || st_r == rbd_pkg::DS_READ) && dma_ack;
  assign blk_full = byte_done && blk_r + 32'h1 == notify_r;
  assign pos_sum = pos_r + avs_writedata;
  // Card to host pops at the start of a write; the output path pops in the other direction
  assign pop = !gen && st_r == rbd_pkg::DS_IDLE && run_r && free_r != 32'h0 && cnt_r != '0;

  always_comb
  begin
    st_nxt = st_r;
    run_nxt = run_r;
    ovr_nxt = ovr_r || ovr_hit; // Sticky until the next start
    unr_nxt = unr_r;
    primed_nxt = primed_r;
    ready_nxt = ready_r;
    free_nxt = free_r;
    pos_nxt = pos_r;
    off_nxt = off_r;
    blk_nxt = blk_r;
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    evt_nxt = 1'b0;
    wp_nxt = wp_r + (push ? FIFO_AW'(1) : FIFO_AW'(0));
    rp_nxt = rp_r + (mem_pop ? FIFO_AW'(1) : FIFO_AW'(0));
    cnt_nxt = cnt_r + (push ? (FIFO_AW+1)'(1) : (FIFO_AW+1)'(0)) - (mem_pop ? (FIFO_AW+1)'(1) : (FIFO_AW+1)'(0));
    // Run bit is software's, but a stop request also clears it
    if (wr_acc && avs_address == rbd_pkg::REG_CTRL && !avs_writedata[rbd_pkg::CTRL_RUN])
      run_nxt = 1'b0;
    unique case (st_r)
      rbd_pkg::DS_IDLE:
        // Nothing moves while the card has no free bytes
        if (run_r && free_r != 32'h0)
        begin
          // Scatter-gather: page base from the table, low bits from the ring offset
          addr_nxt = {page_r[off_r[rbd_pkg::PAGE_SHIFT +: rbd_pkg::PAGE_IDX_W]][31:rbd_pkg::PAGE_SHIFT],
                      off_r[rbd_pkg::PAGE_SHIFT-1:0]};
          if (pop)
            st_nxt = rbd_pkg::DS_FETCH;
          else if (gen && !unr_r && cnt_r < DEPTH) // Underrun halts host reads
            st_nxt = rbd_pkg::DS_READ;
        end
      rbd_pkg::DS_FETCH:
      begin
        wdat_nxt = mem_q; // Memory answers one edge after the pop
        st_nxt = rbd_pkg::DS_WRITE;
      end
      rbd_pkg::DS_WRITE, rbd_pkg::DS_READ:
        // Request held until the bus grants it; a started byte always completes
        if (dma_ack)
          st_nxt = rbd_pkg::DS_IDLE;
      default:
        st_nxt = rbd_pkg::DS_IDLE;
    endcase
    if (byte_done)
    begin
      free_nxt = free_nxt - 32'h1;
      off_nxt = (off_r + 32'h1 == len_r) ? 32'h0 : off_r + 32'h1;
      blk_nxt = blk_full ? 32'h0 : blk_r + 32'h1;
    end
    if (blk_full)
    begin
      // Only whole blocks are announced; the count is linear so a wrap is included
      ready_nxt = ready_nxt + notify_r;
      evt_nxt = 1'b1;
    end
    if (rel)
    begin
      free_nxt = free_nxt + avs_writedata;
      ready_nxt = ready_nxt - avs_writedata;
      pos_nxt = (pos_sum >= len_r) ? pos_sum - len_r : pos_sum;
    end
    // Output side starts once the FIFO is full or the whole buffer has been fetched
    if (gen && run_r && (cnt_r == DEPTH || free_r == 32'h0))
      primed_nxt = 1'b1;
    if (gen && run_r && primed_r && dac_ready && !dvld_r && !dpend_r && cnt_r == '0)
      unr_nxt = 1'b1;
    if (start)
    begin
      // Fresh buffer: nothing for the host, all of it for the card
      run_nxt = 1'b1;
      ovr_nxt = 1'b0;
      unr_nxt = 1'b0;
      primed_nxt = 1'b0;
      ready_nxt = 32'h0;
      free_nxt = len_r;
      pos_nxt = 32'h0;
      off_nxt = 32'h0;
      blk_nxt = 32'h0;
      wp_nxt = '0;
      rp_nxt = '0;
      cnt_nxt = '0;
    end
  end

  // Registers of the engine
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= rbd_pkg::DS_IDLE;
      run_r <= 1'b0;
      ovr_r <= 1'b0;
      unr_r <= 1'b0;
      primed_r <= 1'b0;
      ready_r <= 32'h0;
      free_r <= 32'h0;
      pos_r <= 32'h0;
      off_r <= 32'h0;
      blk_r <= 32'h0;
      addr_r <= 32'h0;
      wdat_r <= 8'h00;
      evt_r <= 1'b0;
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      run_r <= run_nxt;
      ovr_r <= ovr_nxt;
      unr_r <= unr_nxt;
      primed_r <= primed_nxt;
      ready_r <= ready_nxt;
      free_r <= free_nxt;
      pos_r <= pos_nxt;
      off_r <= off_nxt;
      blk_r <= blk_nxt;
      addr_r <= addr_nxt;
      wdat_r <= wdat_nxt;
      evt_r <= evt_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage: one byte at a time; one byte every three cycles is the price of a simple pop
  always_comb
  begin
    dpend_nxt = mem_pop && gen;
    dvld_nxt = dvld_r;
    ddat_nxt = ddat_r;
    if (dpend_r)
    begin
      dvld_nxt = 1'b1;
      ddat_nxt = mem_q;
    end
    else if (dvld_r && dac_ready)
    begin
      dvld_nxt = 1'b0;
    end
    if (start)
      dvld_nxt = 1'b0;
  end

  // Registers of the output stage
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dvld_r <= 1'b0;
      dpend_r <= 1'b0;
      ddat_r <= 8'h00;
    end
    else
    begin
      dvld_r <= dvld_nxt;
      dpend_r <= dpend_nxt;
      ddat_r <= ddat_nxt;
    end
  end

  assign dac_valid = dvld_r;
  assign dac_data = ddat_r;
  assign data_avail_evt = evt_r;
  assign dma_cmd = '{req: (st_r == rbd_pkg::DS_WRITE || st_r == rbd_pkg::DS_READ),
                     wr: (st_r == rbd_pkg::DS_WRITE), addr: addr_r, wdata: wdat_r};

endmodule // rbd_ring_dma

// File: bench/rbd_ring_dma_assertions.sv
// Checker of the ring buffer DMA engine ports.
`timescale 1ns/1ns
module rbd_ring_dma_assertions #(
  parameter int FIFO_AW = 10
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input rbd_pkg::rbd_dma_req_t dma_cmd,
  input wire logic dma_ack,
  input wire logic data_avail_evt
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Register bus: exactly one wait state
  chk_first_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait state");
  chk_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait state too long");
  // Release register is write only, so it reads zero
  chk_release_rd: assert property (avs_read && !avs_waitrequest && avs_address == 8'h0c |-> avs_readdata == '0)
    else $error("release register read not zero");
  ////////////////////////////////////////
  // Busmaster byte held until acknowledged
  chk_req_hold: assert property (dma_cmd.req && !dma_ack |=> dma_cmd.req && $stable(dma_cmd.addr))
    else $error("request dropped or moved");
  chk_data_hold: assert property (dma_cmd.req && !dma_ack |=> $stable(dma_cmd.wdata) && $stable(dma_cmd.wr))
    else $error("write byte changed while pending");
  // Idle then fetch before the next write byte
  chk_ack_gap: assert property (dma_ack && dma_cmd.wr |=> !dma_cmd.req [*2])
    else $error("next byte too soon");
  ////////////////////////////////////////
  // Notify pulse follows a completed byte
  chk_evt_cause: assert property (data_avail_evt |-> $past(dma_ack))
    else $error("event without completed byte");
  chk_evt_spacing: assert property (data_avail_evt |=> !data_avail_evt [*8])
    else $error("events closer than one block");
endmodule // rbd_ring_dma_assertions
bind rbd_ring_dma rbd_ring_dma_assertions #(.FIFO_AW(FIFO_AW)) i_rbd_ring_dma_assertions (.core_clk, .rst_n,
  .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .dma_cmd, .dma_ack, .data_avail_evt);

// File: bench/rbd_host_mem.sv
// Host memory model behind the busmaster byte port.
`timescale 1ns/1ns
module rbd_host_mem (
  input wire logic core_clk,
  input rbd_pkg::rbd_dma_req_t dma_cmd,
  input wire logic slow,
  output logic dma_ack,
  output logic [7:0] dma_rdata
);
  logic [7:0] mem [8192]; // Buffer pages live in the low 8 kByte
  logic [1:0] wait_r = 2'h0; // Cycles waited on the pending byte
  initial
  begin
    dma_ack = 1'b0;
    dma_rdata = 8'h00;
  end
  ////////////////////////////////////////
  // Answer each byte once, at once or three cycles late
  always @(posedge core_clk)
  begin
    dma_ack <= 1'b0;
    dma_rdata <= ~dma_rdata; // Never a stale byte between answers
    if (dma_cmd.req === 1'b1 && !dma_ack)
    begin
      wait_r <= wait_r + 2'h1;
      if (wait_r == {slow, slow})
      begin
        wait_r <= 2'h0;
        dma_ack <= 1'b1;
        dma_rdata <= mem[dma_cmd.addr[12:0]];
        if (dma_cmd.wr)
          mem[dma_cmd.addr[12:0]] <= dma_cmd.wdata;
      end
    end
  end
endmodule // rbd_host_mem

// File: bench/rbd_ring_dma_test.sv
// Self-checking bench of the ring buffer DMA engine, both transfer directions.
`timescale 1ns/1ns
module rbd_ring_dma_test;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0; // Held low for 8 cycles
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic adc_round_valid = 1'b0;
  rbd_pkg::rbd_round_t adc_round = '0;
  logic dac_ready = 1'b0; // Output path idle
  logic slow = 1'b0; // Late host answers
  logic [31:0] avs_readdata, q;
  logic [7:0] dac_data, dma_rdata;
  logic avs_waitrequest, dac_valid, dma_ack, data_avail_evt;
  rbd_pkg::rbd_dma_req_t dma_cmd;
  int fails = 0;
  int tests_run = 0;
  int evts = 0; // Notify pulses seen
  int cyc = 0; // Hang guard
  int ord [4] = '{0, 2, 1, 3}; // Four channel round order
  rbd_ring_dma #(.FIFO_AW(4)) i_rbd_ring_dma (.*);
  rbd_host_mem i_rbd_host_mem (.*);
  ////////////////////////////////////////
  initial
  begin
    forever #5 core_clk = ~core_clk;
  end
  // Count events; cut a hang short
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (data_avail_evt === 1'b1)
      evts <= evts + 1;
    if (cyc == 20000)
    begin
      fails++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One Avalon access: held until the rising edge that samples waitrequest low, data taken there
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge core_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // One idle edge so a strobe is never lowered and raised in one time step
    @(posedge core_clk);
  endtask
  // Read, retrying up to n times while the engine drains
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input int n);
    bus(1'b0, a, 32'h0);
    for (int i = 0; i < n && q !== exp; i++)
      bus(1'b0, a, 32'h0);
    cmp($sformatf("register %h", a), exp, q);
  endtask
  function automatic logic [7:0] pat(input int k, input int m, input int c);
    return {k[4:0], m[0], c[1:0]};
  endfunction
  task automatic rnd(input int k);
    for (int m = 0; m < 2; m++)
      for (int c = 0; c < 4; c++)
        adc_round.smp[m][c] <= pat(k, m, c);
    adc_round_valid <= 1'b1;
    @(posedge core_clk);
    adc_round_valid <= 1'b0;
    repeat (23) @(posedge core_clk);
  endtask
  task automatic mem(input int off, input int k, input int m, input int c);
    cmp("host byte", {24'h0, pat(k, m, c)}, {24'h0, i_rbd_host_mem.mem[32'h1000 + off]});
  endtask
  ////////////////////////////////////////
  // Main sequence: 48 byte ring, 16 byte notify, 16 byte FIFO
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(8'h00, 32'h10, 0);
    rd(8'h04, 32'h8000, 0);
    bus(1'b1, 8'hfc, 32'hffff);
    rd(8'hfc, 32'h0, 0);
    rd(8'h0c, 32'h0, 0);
    bus(1'b1, 8'h04, 32'h30);
    bus(1'b1, 8'h08, 32'h10);
    bus(1'b1, 8'h20, 32'h1000);
    bus(1'b1, 8'h00, 32'hf1);
    rd(8'h10, 32'h0, 0);
    rd(8'h18, 32'h30, 0);
    rd(8'h14, 32'h0, 0);
    for (int k = 0; k < 5; k++)
      rnd(k);
    rd(8'h18, 32'h1c, 300);
    rd(8'h10, 32'h10, 0);
    cmp("events", 1, evts);
    for (int j = 0; j < 20; j++)
      mem(j, j / 4, 0, ord[j % 4]);
    bus(1'b1, 8'h0c, 32'h10);
    rd(8'h14, 32'h10, 0);
    rd(8'h10, 32'h0, 0);
    for (int k = 5; k < 16; k++)
      rnd(k);
    rd(8'h18, 32'h0, 300);
    rd(8'h10, 32'h30, 0);
    for (int j = 0; j < 16; j++)
      mem(j, 12 + j / 4, 0, ord[j % 4]);
    for (int k = 16; k < 21; k++)
      rnd(k);
    bus(1'b0, 8'h1c, 32'h0);
    cmp("overrun flag", 32'h2, q & 32'h2);
    slow <= 1'b1;
    bus(1'b1, 8'h0c, 32'h10);
    rd(8'h14, 32'h20, 0);
    rd(8'h18, 32'h0, 300);
    rd(8'h10, 32'h30, 0);
    cmp("events", 5, evts);
    for (int j = 0; j < 16; j++)
      mem(16 + j, 16 + j / 4, 0, ord[j % 4]);
    bus(1'b0, 8'h1c, 32'h0);
    cmp("overrun kept", 32'h2, q & 32'h2);
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h00, 32'h131);
    rnd(24);
    rnd(25);
    rd(8'h18, 32'h28, 300);
    for (int j = 0; j < 8; j++)
      mem(j, 24 + j / 4, j % 2, (j / 2) % 2);
    bus(1'b0, 8'h1c, 32'h0);
    cmp("overrun cleared", 32'h0, q & 32'h2);
    // Host to card, one channel: bytes just written come back out from offset zero
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h00, 32'h13);
    dac_ready <= 1'b1;
    for (int j = 0; j < 8; j++)
    begin
      @(posedge core_clk);
      while (dac_valid !== 1'b1)
        @(posedge core_clk);
      cmp("output byte", {24'h0, pat(24 + j / 4, j % 2, (j / 2) % 2)}, {24'h0, dac_data});
    end
    // Slow host answers cannot keep up with the output, so the FIFO runs dry
    rd(8'h1c, 32'h15, 300);
    conclude();
  end
endmodule // rbd_ring_dma_test
